// ### actr_regs_map.vh
// Register map, field positions and constants of the channel tuning register bank
// What this block does
// R1 - Bit 0 of the channel B high-frequency register selects high-input-frequency mode (1) over default performance (0), advised above 200MHz.
// R2 - Address 58h bit 0 selects high-input-frequency mode for channel A in the same way.
// R3 - Software writes zero to every unused bit of these registers.
// R4 - With offset correction on, channel A converges to mid-scale plus the pedestal held in bits 7 to 5 at BFh.
// R5 - The 3-bit pedestal is signed: 000 to 100 give 0 to +4 LSB, 111, 110, 101 give -1, -2, -3 LSB.
// R6 - Channel B has its own pedestal in bits 7 to 5 at C1h with the same coding.
// R7 - Bit 7 at CFh freezes offset estimation and reuses the last estimate every cycle; both states need offset correction enabled.
// R8 - Bits 5 to 2 at CFh hold the offset loop time constant in clock cycles.
// R9 - Bit 0 at DBh enables channel B low-speed mode.
// R10 - Software sets the global low-speed register-control bit before using the channel B low-speed bit.
// R11 - Every register of the bank resets to 00h.
// R12 - With the global low-speed control bit at 0 low-speed mode follows the serial clock pin level, at 1 the register bits rule.
// R13 - Bit 7 at EAh lets register settings override the noise-shaping control pins.
`ifndef ACTR_REGS_MAP_VH
`define ACTR_REGS_MAP_VH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define ACTR_ADDR_READOUT      8'h00
`define ACTR_ADDR_CHB_HIFREQ   8'h4a
`define ACTR_ADDR_CHA_HIFREQ   8'h58
`define ACTR_ADDR_CHA_PED      8'hbf
`define ACTR_ADDR_CHB_PED      8'hc1
`define ACTR_ADDR_OFS_LOOP     8'hcf
`define ACTR_ADDR_CHB_SLOW     8'hdb
`define ACTR_ADDR_PIN_OVR      8'hea

// ----------------------------------------
// Fields
// ----------------------------------------
`define ACTR_REG_RESET         8'h00
`define ACTR_BIT_READOUT       0
`define ACTR_BIT_HIFREQ        0
`define ACTR_PED_MSB           7
`define ACTR_PED_LSB           5
`define ACTR_BIT_HOLD          7
`define ACTR_TAU_MSB           5
`define ACTR_TAU_LSB           2
`define ACTR_BIT_SLOW          0
`define ACTR_BIT_OVR           7

// ----------------------------------------
// Serial frame and converter constants
// ----------------------------------------
`define ACTR_FRAME_BITS        5'h10
`define ACTR_ADDR_BITS         5'h08
`define ACTR_MIDCODE           11'h400
`define ACTR_PED_PLUS4         3'h4

`endif

// ### actr_sync.v
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module actr_sync #(
    parameter W = 1
) (
    input  wire         ref_clk,
    input  wire         resetn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    // First stage is read only by the second stage
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // actr_sync

// ### actr_pedestal_decode.v
// Pedestal code decoder giving the converged target code of one channel
`timescale 1ns/1ps
`include "actr_regs_map.vh"
module actr_pedestal_decode (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire [2:0]  ped_code,
    output wire [10:0] offset_target
);
    reg  [10:0] target_r;
    wire [3:0]  ped_signed;
    wire [10:0] ped_ext;

    // 100 is +4, the other codes are plain two's complement [R5]
    assign ped_signed = {(ped_code == `ACTR_PED_PLUS4) ? 1'b0 : ped_code[2], ped_code};
    assign ped_ext    = {{7{ped_signed[3]}}, ped_signed};

    always @(posedge ref_clk)
    begin
        if (!resetn)
            target_r <= `ACTR_MIDCODE;
        else
            target_r <= `ACTR_MIDCODE + ped_ext; // [R4] [R6]
    end

    assign offset_target = target_r;
endmodule // actr_pedestal_decode

// ### actr_top.v
// Channel tuning register bank behind the serial configuration port
`timescale 1ns/1ps
`include "actr_regs_map.vh"
module actr_top (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        sen_n,
    input  wire        sclk,
    input  wire        sdata,
    output wire        sdout,
    input  wire        offset_loop_enable,
    input  wire        low_speed_reg_ctrl,
    input  wire        ns_pin_cha,
    input  wire        ns_pin_chb,
    input  wire        ns_reg_cha,
    input  wire        ns_reg_chb,
    output wire        cha_high_input_freq_sel,
    output wire        chb_high_input_freq_sel,
    output wire [2:0]  cha_pedestal_code,
    output wire [2:0]  chb_pedestal_code,
    output wire [10:0] cha_offset_target,
    output wire [10:0] chb_offset_target,
    output wire        offset_estimate_hold,
    output wire        offset_estimate_run,
    output wire [3:0]  offset_loop_tau,
    output wire        chb_slow_rate_enable,
    output wire        noise_shaping_pin_override,
    output wire        ns_enable_cha,
    output wire        ns_enable_chb
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [4:0] pins_s;
    wire       sen_n_s;
    wire       sclk_s;
    wire       sdata_s;
    wire       ns_pin_cha_s;
    wire       ns_pin_chb_s;

    actr_sync #(
        .W (5)
    ) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({ns_pin_chb, ns_pin_cha, sdata, sclk, ~sen_n}),
        .sync_out (pins_s)
    );

    // Enable is inverted before the flops so reset reads as idle
    assign sen_n_s      = ~pins_s[0];
    assign sclk_s       = pins_s[1];
    assign sdata_s      = pins_s[2];
    assign ns_pin_cha_s = pins_s[3];
    assign ns_pin_chb_s = pins_s[4];
    // All pins see the same two flops, so data and clock stay aligned

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg        readout_r;
    reg        cha_hifreq_r;
    reg        chb_hifreq_r;
    reg  [2:0] cha_ped_r;
    reg  [2:0] chb_ped_r;
    reg        hold_r;
    reg  [3:0] tau_r;
    reg        chb_slow_r;
    reg        pin_ovr_r;

    // ----------------------------------------
    // Serial frame capture
    // ----------------------------------------
    reg        sclk_d_r;
    reg  [4:0] bit_cnt_r;
    reg  [4:0] bit_cnt_nxt;
    reg [15:0] shift_r;
    reg [15:0] shift_nxt;
    reg        wr_r;
    reg        wr_nxt;
    reg  [7:0] rd_sh_r;
    reg  [7:0] rd_sh_nxt;
    reg        sdout_r;
    reg  [7:0] rd_data;
    wire       sclk_rise;
    wire       sclk_fall;
    wire [7:0] frame_addr;
    wire [7:0] frame_data;
    wire [7:0] live_addr;

    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    assign sclk_rise  = sclk_s & ~sclk_d_r;
    assign sclk_fall  = ~sclk_s & sclk_d_r;
    assign frame_addr = shift_r[15:8];
    assign frame_data = shift_r[7:0];
    // Address as it stands the instant the eighth bit arrives
    assign live_addr  = {shift_r[6:0], sdata_s};

    always @*
    begin
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt   = shift_r;
        wr_nxt      = 1'b0;
        rd_sh_nxt   = rd_sh_r;
        if (sen_n_s)
        begin
            // A frame cut short never writes
            bit_cnt_nxt = 5'h00;
        end
        else if (sclk_rise && bit_cnt_r != `ACTR_FRAME_BITS)
        begin
            shift_nxt   = {shift_r[14:0], sdata_s};
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == `ACTR_FRAME_BITS - 5'h01)
                wr_nxt = 1'b1;
            if (bit_cnt_r == `ACTR_ADDR_BITS - 5'h01)
                rd_sh_nxt = read_mux(live_addr);
        end
        else if (sclk_fall && bit_cnt_r > `ACTR_ADDR_BITS)
        begin
            rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
        end
    end

    // Reserved bits read as zero
    function [7:0] read_mux;
        input [7:0] addr;
        begin
            read_mux = `ACTR_REG_RESET;
            if (hit(addr, `ACTR_ADDR_READOUT))
                read_mux[`ACTR_BIT_READOUT] = readout_r;
            if (hit(addr, `ACTR_ADDR_CHB_HIFREQ))
                read_mux[`ACTR_BIT_HIFREQ] = chb_hifreq_r;
            if (hit(addr, `ACTR_ADDR_CHA_HIFREQ))
                read_mux[`ACTR_BIT_HIFREQ] = cha_hifreq_r;
            if (hit(addr, `ACTR_ADDR_CHA_PED))
                read_mux[`ACTR_PED_MSB:`ACTR_PED_LSB] = cha_ped_r;
            if (hit(addr, `ACTR_ADDR_CHB_PED))
                read_mux[`ACTR_PED_MSB:`ACTR_PED_LSB] = chb_ped_r;
            if (hit(addr, `ACTR_ADDR_OFS_LOOP))
            begin
                read_mux[`ACTR_BIT_HOLD] = hold_r;
                read_mux[`ACTR_TAU_MSB:`ACTR_TAU_LSB] = tau_r;
            end
            if (hit(addr, `ACTR_ADDR_CHB_SLOW))
                read_mux[`ACTR_BIT_SLOW] = chb_slow_r;
            if (hit(addr, `ACTR_ADDR_PIN_OVR))
                read_mux[`ACTR_BIT_OVR] = pin_ovr_r;
        end
    endfunction

    always @*
    begin
        rd_data = read_mux(frame_addr);
    end

    always @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            sclk_d_r  <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_r   <= 16'h0000;
            wr_r      <= 1'b0;
            rd_sh_r   <= 8'h00;
            sdout_r   <= 1'b0;
        end
        else
        begin
            sclk_d_r  <= sclk_s;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r   <= shift_nxt;
            wr_r      <= wr_nxt;
            rd_sh_r   <= rd_sh_nxt;
            // Readback only drives while a frame is open and readout is on
            sdout_r   <= readout_r & ~sen_n_s & (bit_cnt_r >= `ACTR_ADDR_BITS) & rd_sh_nxt[7];
        end
    end

    assign sdout = sdout_r;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // A write lands two cycles after the sixteenth rising edge is seen
    wire wr_ok;
    // In readout mode only the readout register itself accepts writes
    assign wr_ok = wr_r & (~readout_r | hit(frame_addr, `ACTR_ADDR_READOUT));

    always @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            // Every register comes up at 00h [R11]
            readout_r    <= 1'b0;
            cha_hifreq_r <= 1'b0;
            chb_hifreq_r <= 1'b0;
            cha_ped_r    <= 3'h0;
            chb_ped_r    <= 3'h0;
            hold_r       <= 1'b0;
            tau_r        <= 4'h0;
            chb_slow_r   <= 1'b0;
            pin_ovr_r    <= 1'b0;
        end
        else if (wr_ok)
        begin
            // Only field bits are stored; the rest are dropped [R3]
            if (hit(frame_addr, `ACTR_ADDR_READOUT))
                readout_r <= frame_data[`ACTR_BIT_READOUT];
            if (hit(frame_addr, `ACTR_ADDR_CHB_HIFREQ))
                chb_hifreq_r <= frame_data[`ACTR_BIT_HIFREQ]; // [R1]
            if (hit(frame_addr, `ACTR_ADDR_CHA_HIFREQ))
                cha_hifreq_r <= frame_data[`ACTR_BIT_HIFREQ]; // [R2]
            if (hit(frame_addr, `ACTR_ADDR_CHA_PED))
                cha_ped_r <= frame_data[`ACTR_PED_MSB:`ACTR_PED_LSB]; // [R4]
            if (hit(frame_addr, `ACTR_ADDR_CHB_PED))
                chb_ped_r <= frame_data[`ACTR_PED_MSB:`ACTR_PED_LSB]; // [R6]
            if (hit(frame_addr, `ACTR_ADDR_OFS_LOOP))
            begin
                hold_r <= frame_data[`ACTR_BIT_HOLD]; // [R7]
                tau_r  <= frame_data[`ACTR_TAU_MSB:`ACTR_TAU_LSB]; // [R8]
            end
            if (hit(frame_addr, `ACTR_ADDR_CHB_SLOW))
                chb_slow_r <= frame_data[`ACTR_BIT_SLOW]; // [R9]
            if (hit(frame_addr, `ACTR_ADDR_PIN_OVR))
                pin_ovr_r <= frame_data[`ACTR_BIT_OVR]; // [R13]
        end
    end

    // ----------------------------------------
    // Pedestal targets
    // ----------------------------------------
    actr_pedestal_decode u_ped_cha (
        .ref_clk       (ref_clk),
        .resetn        (resetn),
        .ped_code      (cha_ped_r),
        .offset_target (cha_offset_target)
    );

    actr_pedestal_decode u_ped_chb (
        .ref_clk       (ref_clk),
        .resetn        (resetn),
        .ped_code      (chb_ped_r),
        .offset_target (chb_offset_target)
    );

    // ----------------------------------------
    // Mode outputs
    // ----------------------------------------
    // The loop, low-speed and noise-shaping enable outputs are registered so each changes on a clock edge,
    // one cycle after the register, input or synchronised pin that steers it
    reg hold_out_r;
    reg run_out_r;
    reg slow_out_r;
    reg ns_cha_r;
    reg ns_chb_r;

    always @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            hold_out_r <= 1'b0;
            run_out_r  <= 1'b0;
            slow_out_r <= 1'b0;
            ns_cha_r   <= 1'b0;
            ns_chb_r   <= 1'b0;
        end
        else
        begin
            // Hold and run both mean nothing with the loop off [R7]
            hold_out_r <= offset_loop_enable & hold_r;
            run_out_r  <= offset_loop_enable & ~hold_r;
            // Pin level rules until software takes control [R12] [R10]
            slow_out_r <= low_speed_reg_ctrl ? chb_slow_r : sclk_s;
            // Register settings beat the pins only when overriding [R13]
            ns_cha_r   <= pin_ovr_r ? ns_reg_cha : ns_pin_cha_s;
            ns_chb_r   <= pin_ovr_r ? ns_reg_chb : ns_pin_chb_s;
        end
    end

    assign cha_high_input_freq_sel    = cha_hifreq_r;
    assign chb_high_input_freq_sel    = chb_hifreq_r;
    assign cha_pedestal_code          = cha_ped_r;
    assign chb_pedestal_code          = chb_ped_r;
    assign offset_estimate_hold       = hold_out_r;
    assign offset_estimate_run        = run_out_r;
    assign offset_loop_tau            = tau_r;
    assign chb_slow_rate_enable       = slow_out_r;
    assign noise_shaping_pin_override = pin_ovr_r;
    assign ns_enable_cha              = ns_cha_r;
    assign ns_enable_chb              = ns_chb_r;

endmodule // actr_top

// ### actr_top_assertions.sv
// Concurrent checks on the outputs of the tuning register bank
`timescale 1ns/1ps
module actr_top_checker (
    input wire        ref_clk,
    input wire        resetn,
    input wire        sclk,
    input wire        offset_loop_enable,
    input wire        low_speed_reg_ctrl,
    input wire        ns_reg_cha,
    input wire        ns_reg_chb,
    input wire        cha_high_input_freq_sel,
    input wire        chb_high_input_freq_sel,
    input wire [2:0]  cha_pedestal_code,
    input wire [2:0]  chb_pedestal_code,
    input wire [10:0] cha_offset_target,
    input wire [10:0] chb_offset_target,
    input wire        offset_estimate_hold,
    input wire        offset_estimate_run,
    input wire [3:0]  offset_loop_tau,
    input wire        chb_slow_rate_enable,
    input wire        noise_shaping_pin_override,
    input wire        ns_enable_cha,
    input wire        ns_enable_chb
);
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Code 100 means +4, so it is not sign-extended
    wire        sgn_a  = cha_pedestal_code[2] & (cha_pedestal_code != 3'h4);
    wire        sgn_b  = chb_pedestal_code[2] & (chb_pedestal_code != 3'h4);
    wire [10:0] sext_a = {{8{sgn_a}}, cha_pedestal_code};
    wire [10:0] sext_b = {{8{sgn_b}}, chb_pedestal_code};
    // Five steady samples cover the two pin flops plus the output register
    sequence s_pin_steady;
        (!low_speed_reg_ctrl && $stable(sclk))[*5];
    endsequence
    property p_reset_zero;
        !$past(resetn) |-> !(cha_high_input_freq_sel || chb_high_input_freq_sel
            || noise_shaping_pin_override) && cha_pedestal_code == 3'h0
            && chb_pedestal_code == 3'h0 && offset_loop_tau == 4'h0;
    endproperty
    property p_hold_gate;
        !$past(offset_loop_enable) |-> !offset_estimate_hold && !offset_estimate_run;
    endproperty
    property p_excl;
        !(offset_estimate_hold && offset_estimate_run);
    endproperty
    property p_tgt_a;
        cha_offset_target == 11'h400 + $past(sext_a);
    endproperty
    property p_tgt_b;
        chb_offset_target == 11'h400 + $past(sext_b);
    endproperty
    property p_ns_a;
        $past(noise_shaping_pin_override) |-> ns_enable_cha == $past(ns_reg_cha);
    endproperty
    property p_ns_b;
        $past(noise_shaping_pin_override) |-> ns_enable_chb == $past(ns_reg_chb);
    endproperty
    property p_slow_pin;
        s_pin_steady |-> chb_slow_rate_enable == sclk;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value");
    a_hold_gate: assert property (p_hold_gate) else $error("loop off");
    a_excl: assert property (p_excl) else $error("hold and run");
    a_tgt_a: assert property (p_tgt_a) else $error("target a");
    a_tgt_b: assert property (p_tgt_b) else $error("target b");
    a_ns_a: assert property (p_ns_a) else $error("override a");
    a_ns_b: assert property (p_ns_b) else $error("override b");
    a_slow_pin: assert property (p_slow_pin) else $error("slow pin");
endmodule // actr_top_checker

bind actr_top actr_top_checker u_chk (
    .ref_clk, .resetn, .sclk, .offset_loop_enable, .low_speed_reg_ctrl,
    .ns_reg_cha, .ns_reg_chb, .cha_high_input_freq_sel, .chb_high_input_freq_sel,
    .cha_pedestal_code, .chb_pedestal_code, .cha_offset_target, .chb_offset_target,
    .offset_estimate_hold, .offset_estimate_run, .offset_loop_tau,
    .chb_slow_rate_enable, .noise_shaping_pin_override, .ns_enable_cha, .ns_enable_chb
);

// ### actr_top_tb.sv
// Self-checking bench for the tuning register bank
`timescale 1ns/1ps
module actr_top_tb;
    // ----------------
    // Signals
    // ----------------
    reg         ref_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         sen_n = 1'b1;
    reg         sclk = 1'b0;
    reg         sdata = 1'b0;
    reg         offset_loop_enable = 1'b1;
    reg         low_speed_reg_ctrl = 1'b1;
    reg         ns_pin_cha = 1'b0;
    reg         ns_pin_chb = 1'b1;
    reg         ns_reg_cha = 1'b1;
    reg         ns_reg_chb = 1'b0;
    wire        sdout, cha_high_input_freq_sel, chb_high_input_freq_sel;
    wire        offset_estimate_hold, offset_estimate_run, chb_slow_rate_enable;
    wire        noise_shaping_pin_override, ns_enable_cha, ns_enable_chb;
    wire [2:0]  cha_pedestal_code, chb_pedestal_code;
    wire [10:0] cha_offset_target, chb_offset_target;
    wire [3:0]  offset_loop_tau;
    wire [15:0] snap = {cha_high_input_freq_sel, chb_high_input_freq_sel, cha_pedestal_code,
        chb_pedestal_code, offset_loop_tau, noise_shaping_pin_override,
        chb_slow_rate_enable, offset_estimate_hold, offset_estimate_run};
    reg  [31:0] rows [0:9];
    reg  [47:0] adrs = 48'h58bfc1cfdbea;
    reg  [7:0]  q = 8'h00;
    reg  [2:0]  c;
    integer     n_errors = 0, n_compared = 0, cyc = 0, i;

    actr_top uut (
        .ref_clk, .resetn, .sen_n, .sclk, .sdata, .sdout, .offset_loop_enable,
        .low_speed_reg_ctrl, .ns_pin_cha, .ns_pin_chb, .ns_reg_cha, .ns_reg_chb,
        .cha_high_input_freq_sel, .chb_high_input_freq_sel, .cha_pedestal_code,
        .chb_pedestal_code, .cha_offset_target, .chb_offset_target,
        .offset_estimate_hold, .offset_estimate_run, .offset_loop_tau,
        .chb_slow_rate_enable, .noise_shaping_pin_override, .ns_enable_cha, .ns_enable_chb
    );

    // ----------------
    // Clock, timeout and tasks
    // ----------------
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    // Sclk phases of 5 cycles each, since the pins pass two flops first
    task frame(input [7:0] a, input [7:0] d, input integer n);
        reg [15:0] f;
        integer k;
    begin
        f = {a, d};
        sen_n <= 1'b0;
        for (k = 15; k > 15 - n; k = k - 1)
        begin
            sdata <= f[k];
            sclk <= 1'b0;
            repeat (5) @(posedge ref_clk);
            if (k < 8)
                q[k] = sdout;
            sclk <= 1'b1;
            repeat (5) @(posedge ref_clk);
        end
        sclk <= 1'b0;
        repeat (3) @(posedge ref_clk);
        sen_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
    end
    endtask
    // Converged target: mid-scale plus the signed pedestal, 100 being +4
    function [10:0] tgt(input [2:0] p);
        tgt = 11'h400 + {{8{p[2] & (p != 3'h4)}}, p};
    endfunction
    task summarize;
    begin
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // ----------------
    // Sequence
    // ----------------
    initial
    begin
        rows[0] = 32'h5801_8001;
        rows[1] = 32'h4a01_c001;
        rows[2] = 32'hbfa0_e801;
        rows[3] = 32'hc180_ec01;
        rows[4] = 32'hcf3c_ecf1;
        rows[5] = 32'hcf80_ec02;
        rows[6] = 32'hdb01_ec06;
        rows[7] = 32'hea80_ec0e;
        rows[8] = 32'h5800_6c0e;
        rows[9] = 32'h77ff_6c0e;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(snap, 16'h0001, "reset");
        for (i = 0; i < 10; i = i + 1)
        begin
            frame(rows[i][31:24], rows[i][23:16], 16);
            check(snap, rows[i][15:0], "row");
        end
        check({ns_enable_cha, ns_enable_chb}, 2'b10, "ns_on");
        offset_loop_enable <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({offset_estimate_hold, offset_estimate_run}, 2'b00, "loop_off");
        offset_loop_enable <= 1'b1;
        // A frame cut short must leave every register alone
        frame(8'h58, 8'h01, 15);
        check(snap, 16'h6c0e, "short");
        low_speed_reg_ctrl <= 1'b0;
        sclk <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check(chb_slow_rate_enable, 1'b1, "pin_hi");
        sclk <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check(chb_slow_rate_enable, 1'b0, "pin_lo");
        low_speed_reg_ctrl <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(chb_slow_rate_enable, 1'b1, "reg_ctl");
        for (i = 0; i < 8; i = i + 1)
        begin
            c = i[2:0];
            frame(8'hbf, {c, 5'h00}, 16);
            frame(8'hc1, {~c, 5'h00}, 16);
            check({cha_offset_target, chb_offset_target}, {tgt(c), tgt(~c)}, "targets");
        end
        frame(8'h00, 8'h01, 16);
        frame(8'hcf, 8'h00, 16);
        check(q, 8'h80, "rd_cf");
        frame(8'h58, 8'h01, 16);
        check({q, cha_high_input_freq_sel}, 9'h000, "rd_58");
        resetn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(snap, 16'h0001, "reset2");
        check({cha_offset_target, chb_offset_target}, {11'h400, 11'h400}, "tgt2");
        check({ns_enable_cha, ns_enable_chb}, 2'b01, "ns_off");
        frame(8'h00, 8'h01, 16);
        for (i = 0; i < 6; i = i + 1)
        begin
            frame(adrs[8 * i +: 8], 8'h00, 16);
            check(q, 8'h00, "rd_rst");
        end
        summarize;
    end
endmodule // actr_top_tb
